// [sto_params.svh]
`ifndef STO_PARAMS_SVH
`define STO_PARAMS_SVH

// Reset values of the software-visible control bits
`define STO_ENABLE_RST      1'b0
`define STO_WEN_RST         1'b0
`define STO_AON_RST         1'b0
`define STO_EWIE_RST        1'b0

// Reset values of the timing setup, in supervisor ticks
`define STO_PERIOD_RST      16'h0400
`define STO_WINDOW_RST      16'h0200
`define STO_LEAD_RST        16'h0100

// Counter restart value
`define STO_COUNT_ZERO      16'h0000

`endif

// [sto_pkg.sv]
package sto_pkg;

   // Control bits written together, as one write of the primary control
   typedef struct packed {
      logic enable;
      logic wen;
      logic always_on;
   } sto_ctrl_type;

   // Timing setup fields
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] window;
   } sto_timing_type;

   // Per-item write synchronisation busy flags
   typedef struct packed {
      logic enable;
      logic wen;
      logic always_on;
      logic clear;
   } sto_busy_type;

   // Operating mode as seen by the counting logic
   typedef enum logic [3:0] {
      STO_OFF       = 4'h0,
      STO_NORMAL    = 4'h1,
      STO_NORMAL_EW = 4'h2,
      STO_WINDOW    = 4'h4,
      STO_WINDOW_EW = 4'h8
   } sto_mode_type;

endpackage

// [sto_supervisor_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sto_params.svh"

module sto_supervisor_timer #(
   parameter int CNT_W = 16
) (
   // Clock, power-on reset and clock enable
   input  wire  logic                    i_clk,
   input  wire  logic                    i_rst,
   input  wire  logic                    i_ce,
   // Supervisor tick clock, arrives from the oscillator pin
   input  wire  logic                    i_supervisor_tick_clock,
   // Primary control write
   input  wire  logic                    i_ctrl_wr,
   input  wire  sto_pkg::sto_ctrl_type   i_ctrl,
   // Counter clear write
   input  wire  logic                    i_clear_wr,
   // Timing setup write
   input  wire  logic                    i_timing_wr,
   input  wire  sto_pkg::sto_timing_type i_timing,
   // Pre-alert control write
   input  wire  logic                    i_pre_alert_wr,
   input  wire  logic [CNT_W-1:0]        i_pre_alert_lead_field,
   // Pre-alert interrupt enable set and clear strobes
   input  wire  logic                    i_ewie_set,
   input  wire  logic                    i_ewie_clr,
   // Read-back of control and setup
   output logic                          o_enable,
   output logic                          o_wen,
   output logic                          o_persistent_run_bit,
   output logic                          o_ewie,
   output sto_pkg::sto_timing_type       o_timing,
   output logic [CNT_W-1:0]              o_pre_alert_lead_field,
   // Status
   output sto_pkg::sto_busy_type         o_busy,
   output sto_pkg::sto_mode_type         o_mode,
   output logic [CNT_W-1:0]              o_count,
   output logic                          o_pre_alert,
   output logic                          o_period_end
);
   import sto_pkg::*;

   // Tick synchroniser: first stage is read only by the second
   logic tick_meta;
   logic tick_sync;
   logic tick_prev;
   logic tick;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_meta <= 1'b0;
         tick_sync <= 1'b0;
         tick_prev <= 1'b0;
      end else if (i_ce) begin
         tick_meta <= i_supervisor_tick_clock;
         tick_sync <= tick_meta;
         tick_prev <= tick_sync;
      end
   end

   // One tick of the counting domain per rising oscillator edge
   assign tick = tick_sync & ~tick_prev;

   // Software side control state
   logic              enable;
   logic              wen;
   logic              always_on;
   logic              ewie;
   sto_timing_type    timing;
   logic [CNT_W-1:0]  lead;
   sto_busy_type      busy;
   logic              next_enable;
   logic              next_wen;
   logic              next_always_on;
   logic              next_ewie;
   sto_timing_type    next_timing;
   logic [CNT_W-1:0]  next_lead;
   sto_busy_type      next_busy;

   // Counting side state; count and effective controls only updated on a tick, pulses clear a cycle later
   logic              eff_enable;
   logic              eff_wen;
   logic              eff_aon;
   logic [CNT_W-1:0]  count;
   logic              pre_alert;
   logic              period_end;
   logic              next_eff_enable;
   logic              next_eff_wen;
   logic              next_eff_aon;
   logic [CNT_W-1:0]  next_count;
   logic              next_pre_alert;
   logic              next_period_end;

   // Control registers; values read back at once, busy shows the crossing
   always_comb begin
      next_enable    = enable;
      next_wen       = wen;
      next_always_on = always_on;
      next_ewie      = ewie;
      next_timing    = timing;
      next_lead      = lead;
      next_busy      = busy;
      // Pending items are taken over on a tick; a new write in that cycle wins
      if (tick) begin
         next_busy = '0;
      end
      if (i_ctrl_wr) begin
         next_enable    = i_ctrl.enable;
         next_wen       = i_ctrl.wen;
         // Writing zero never clears it, only the power-on reset does
         next_always_on = always_on | i_ctrl.always_on;
         next_busy.enable    = 1'b1;
         next_busy.wen       = 1'b1;
         next_busy.always_on = 1'b1;
      end
      if (i_clear_wr) begin
         next_busy.clear = 1'b1;
      end
      // Setup is frozen once the persistent bit is written
      if (i_timing_wr && !always_on) begin
         next_timing = i_timing;
      end
      if (i_pre_alert_wr && !always_on) begin
         next_lead = i_pre_alert_lead_field;
      end
      // Enable set and clear stay open in all modes; set wins
      if (i_ewie_clr) begin
         next_ewie = 1'b0;
      end
      if (i_ewie_set) begin
         next_ewie = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         enable    <= `STO_ENABLE_RST;
         wen       <= `STO_WEN_RST;
         always_on <= `STO_AON_RST;
         ewie      <= `STO_EWIE_RST;
         timing    <= '{period: `STO_PERIOD_RST, window: `STO_WINDOW_RST};
         lead      <= `STO_LEAD_RST;
         busy      <= '0;
      end else if (i_ce) begin
         enable    <= next_enable;
         wen       <= next_wen;
         always_on <= next_always_on;
         ewie      <= next_ewie;
         timing    <= next_timing;
         lead      <= next_lead;
         busy      <= next_busy;
      end
   end

   // Mode decode, shared by the counter and the status output
   function automatic sto_mode_type mode_of(input logic run, input logic w, input logic ie);
      sto_mode_type m;
      m = STO_OFF;
      if (run) begin
         unique case ({w, ie})
            2'b00: m = STO_NORMAL;
            2'b01: m = STO_NORMAL_EW;
            2'b10: m = STO_WINDOW;
            2'b11: m = STO_WINDOW_EW;
         endcase
      end
      return m;
   endfunction

   sto_mode_type mode;
   logic         running;
   logic [CNT_W-1:0] last;
   logic [CNT_W-1:0] alert_at;

   // Persistent bit overrides the ordinary enable
   assign running  = eff_enable | eff_aon;
   assign mode     = mode_of(running, eff_wen, ewie);
   assign last     = timing.period[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
   // Window mode counts the lead from the opening of the window
   assign alert_at = (mode == STO_WINDOW_EW) ?
                     timing.window[CNT_W-1:0] + lead : lead;

   // Counting side: synchronised items take effect only on a tick
   always_comb begin
      next_eff_enable = eff_enable;
      next_eff_wen    = eff_wen;
      next_eff_aon    = eff_aon;
      next_count      = count;
      next_pre_alert  = 1'b0;
      next_period_end = 1'b0;
      if (tick) begin
         if (busy.enable) begin
            next_eff_enable = enable;
         end
         if (busy.wen) begin
            next_eff_wen = wen;
         end
         if (busy.always_on) begin
            next_eff_aon = always_on;
         end
         if (!running) begin
            next_count = `STO_COUNT_ZERO;
         end else if (busy.clear || count == last) begin
            // A clear or a full period starts a new time-out period
            next_count      = `STO_COUNT_ZERO;
            next_period_end = ~busy.clear;
         end else begin
            next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // Lead ticks counted from the start of each period, from the window opening in window mode
         if (running && !busy.clear && count == alert_at &&
             (mode == STO_NORMAL_EW || mode == STO_WINDOW_EW)) begin
            next_pre_alert = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         eff_enable <= `STO_ENABLE_RST;
         eff_wen    <= `STO_WEN_RST;
         eff_aon    <= `STO_AON_RST;
         count      <= `STO_COUNT_ZERO;
         pre_alert  <= 1'b0;
         period_end <= 1'b0;
      end else if (i_ce) begin
         eff_enable <= next_eff_enable;
         eff_wen    <= next_eff_wen;
         eff_aon    <= next_eff_aon;
         count      <= next_count;
         pre_alert  <= next_pre_alert;
         period_end <= next_period_end;
      end
   end

   // Outputs, all from flip-flops except the mode decode
   assign o_enable               = enable;
   assign o_wen                  = wen;
   assign o_persistent_run_bit   = always_on;
   assign o_ewie                 = ewie;
   assign o_timing               = timing;
   assign o_pre_alert_lead_field = lead;
   assign o_busy                 = busy;
   assign o_mode                 = mode;
   assign o_count                = count;
   assign o_pre_alert            = pre_alert;
   assign o_period_end           = period_end;

endmodule
`default_nettype wire

// [sto_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sto_monitor #(
   parameter int CNT_W = 16
) (
   // Clock, reset and write strobes
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input wire logic                    i_ce,
   input wire logic                    i_clear_wr,
   input wire logic                    i_timing_wr,
   input wire logic                    i_pre_alert_wr,
   input wire logic                    i_ewie_set,
   input wire logic                    i_ewie_clr,
   // Read-back and status
   input wire logic                    o_wen,
   input wire logic                    o_persistent_run_bit,
   input wire logic                    o_ewie,
   input wire sto_pkg::sto_timing_type o_timing,
   input wire logic [CNT_W-1:0]        o_pre_alert_lead_field,
   input wire sto_pkg::sto_busy_type   o_busy,
   input wire sto_pkg::sto_mode_type   o_mode,
   input wire logic                    o_pre_alert
);
   import sto_pkg::*;

   // One domain, so clock and reset are given once
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // Lock and sticky behaviour of the persistent bit
   chk_aon_sticky: assert property (o_persistent_run_bit |=> o_persistent_run_bit)
      else $error("persistent bit fell without reset");
   chk_timing_lock: assert property (
      o_persistent_run_bit && i_ce && i_timing_wr |=> $stable(o_timing))
      else $error("timing changed while locked");
   chk_lead_lock: assert property (
      o_persistent_run_bit && i_ce && i_pre_alert_wr |=> $stable(o_pre_alert_lead_field))
      else $error("lead changed while locked");
   // Enable and counter clear strobes act in the next cycle, enable set wins
   chk_ewie_set: assert property (i_ce && i_ewie_set |=> o_ewie)
      else $error("enable set ignored");
   chk_ewie_clear: assert property (i_ce && i_ewie_clr && !i_ewie_set |=> !o_ewie)
      else $error("enable clear ignored");
   chk_busy_clear: assert property (i_ce && i_clear_wr |=> o_busy.clear)
      else $error("clear busy not raised");
   // Settled always-on picks one of four running modes
   chk_mode_select: assert property (
      o_persistent_run_bit && o_busy == '0 |-> o_mode == sto_mode_type'(4'h1 << {o_wen, o_ewie}))
      else $error("mode wrong under always-on");
   chk_alert_mode: assert property (
      o_pre_alert |-> $past(o_mode) inside {STO_NORMAL_EW, STO_WINDOW_EW})
      else $error("pre-alert while disabled");
endmodule

bind sto_supervisor_timer sto_monitor #(.CNT_W(CNT_W)) sto_monitor_i (
   .i_clk, .i_rst, .i_ce, .i_clear_wr, .i_timing_wr, .i_pre_alert_wr, .i_ewie_set,
   .i_ewie_clr, .o_wen, .o_persistent_run_bit, .o_ewie, .o_timing, .o_pre_alert_lead_field,
   .o_busy, .o_mode, .o_pre_alert);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sto_pkg::*;
   // Inputs, all valued at time zero
   logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_supervisor_tick_clock = 1'b0;
   logic i_ctrl_wr = 1'b0, i_clear_wr = 1'b0, i_timing_wr = 1'b0, i_pre_alert_wr = 1'b0;
   logic i_ewie_set = 1'b0, i_ewie_clr = 1'b0;
   sto_ctrl_type   i_ctrl = '0;
   sto_timing_type i_timing = '0;
   logic [15:0]    i_pre_alert_lead_field = '0;
   // Outputs
   logic o_enable, o_wen, o_persistent_run_bit, o_ewie, o_pre_alert, o_period_end;
   sto_timing_type o_timing;
   logic [15:0]    o_pre_alert_lead_field, o_count;
   sto_busy_type   o_busy;
   sto_mode_type   o_mode;
   int err_total = 0, n_checks = 0, cyc = 0, n_pa = 0, n_pe = 0;
   logic [31:0] rng = 32'hc9cc;

   sto_supervisor_timer sto_supervisor_timer_i (
      .i_clk, .i_rst, .i_ce, .i_supervisor_tick_clock, .i_ctrl_wr, .i_ctrl, .i_clear_wr,
      .i_timing_wr, .i_timing, .i_pre_alert_wr, .i_pre_alert_lead_field, .i_ewie_set,
      .i_ewie_clr, .o_enable, .o_wen, .o_persistent_run_bit, .o_ewie, .o_timing,
      .o_pre_alert_lead_field, .o_busy, .o_mode, .o_count, .o_pre_alert, .o_period_end);

   always #5 i_clk = ~i_clk;

   // Pulse tally, and a ceiling well above the ~1000 cycles the run needs
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_pre_alert === 1'b1) n_pa <= n_pa + 1;
      if (o_period_end === 1'b1) n_pe <= n_pe + 1;
      if (cyc == 6000) begin
         err_total++;
         finish_test();
      end
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (exp !== got) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One-cycle strobe, then a settle cycle so read-back is valid
   task automatic pulse(ref logic s);
      @(negedge i_clk) s = 1'b1;
      @(negedge i_clk) s = 1'b0;
      @(negedge i_clk);
   endtask

   // Oscillator pin pulses; low between them, slow enough for the synchroniser
   task automatic tick(int n);
      repeat (n) begin
         @(negedge i_clk) i_supervisor_tick_clock = 1'b1;
         repeat (3) @(negedge i_clk);
         i_supervisor_tick_clock = 1'b0;
         repeat (3) @(negedge i_clk);
      end
   endtask

   // Forty ticks span exactly two periods of twenty, whatever the phase
   task automatic run(int exp_pa);
      int pa0;
      int pe0;
      pa0 = n_pa;
      pe0 = n_pe;
      tick(40);
      chk("pre_alerts", exp_pa, n_pa - pa0);
      chk("period_ends", 2, n_pe - pe0);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      @(negedge i_clk) i_rst = 1'b0;
      // Setup is open before always-on; normal mode with pre-alert
      i_timing = '{16'h0014, 16'h0008};
      i_pre_alert_lead_field = 16'h0005;
      pulse(i_timing_wr);
      pulse(i_pre_alert_wr);
      chk("timing", 32'h00140008, o_timing);
      chk("lead", 32'h5, 32'(o_pre_alert_lead_field));
      pulse(i_ewie_set);
      i_ctrl = '{1'b1, 1'b0, 1'b0};
      pulse(i_ctrl_wr);
      chk("busy", 32'he, 32'(o_busy));
      chk("enable", 32'h1, 32'(o_enable));
      tick(1);
      chk("busy_done", 32'h0, 32'(o_busy));
      run(2);
      $display("normal run done");
      // Always-on keeps running with enable low and cannot be cleared
      i_ctrl = '{1'b0, 1'b0, 1'b1};
      pulse(i_ctrl_wr);
      tick(1);
      chk("aon", 32'h1, 32'(o_persistent_run_bit));
      run(2);
      i_ctrl = '0;
      pulse(i_ctrl_wr);
      tick(1);
      chk("aon_kept", 32'h1, 32'(o_persistent_run_bit));
      i_timing = xs();
      i_pre_alert_lead_field = xs();
      pulse(i_timing_wr);
      pulse(i_pre_alert_wr);
      chk("timing_lock", 32'h00140008, o_timing);
      chk("lead_lock", 32'h5, 32'(o_pre_alert_lead_field));
      $display("lock test done");
      // All four always-on modes
      for (int k = 0; k < 4; k++) begin
         i_ctrl = '{1'b0, k[1], 1'b1};
         if (k[0]) pulse(i_ewie_set);
         else pulse(i_ewie_clr);
         pulse(i_ctrl_wr);
         tick(1);
         chk("wen", k[1], 32'(o_wen));
         chk("ewie", k[0], 32'(o_ewie));
         chk("mode", 32'h1 << k, 32'(o_mode));
      end
      i_ctrl = '{1'b0, 1'b0, 1'b1};
      pulse(i_ewie_clr);
      pulse(i_ctrl_wr);
      tick(1);
      run(0);
      $display("mode test done");
      // Counter clear crosses on the next tick
      pulse(i_clear_wr);
      chk("busy_clr", 32'h1, 32'(o_busy));
      tick(1);
      chk("count", 32'h0, 32'(o_count));
      @(negedge i_clk) i_rst = 1'b1;
      @(negedge i_clk) i_rst = 1'b0;
      chk("aon_por", 32'h0, 32'(o_persistent_run_bit));
      // Clock enable low freezes state, so a set strobe must not land
      i_ce = 1'b0;
      pulse(i_ewie_set);
      i_ce = 1'b1;
      chk("ewie_frozen", 32'h0, 32'(o_ewie));
      $display("clear and reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
